// ===== drive_words_regs.vh
`ifndef DRIVE_WORDS_REGS_VH
`define DRIVE_WORDS_REGS_VH

// Command word bit positions
`define CMD_PRESET_LO      0
`define CMD_PRESET_HI      1
`define CMD_DC_BRAKE_N     2
`define CMD_COAST_N        3
`define CMD_QSTOP_N        4
`define CMD_FREEZE_N       5
`define CMD_START          6
`define CMD_RESET          7
`define CMD_JOG            8
`define CMD_RAMP2          9
`define CMD_VALID          10
`define CMD_DIG_OUT        11
`define CMD_RELAY          12
`define CMD_SETUP_LO       13
`define CMD_SETUP_HI       14
`define CMD_REVERSE        15

// State word bit positions
`define ST_READY           0
`define ST_DRIVE_READY     1
`define ST_CAN_START       2
`define ST_TRIP            3
`define ST_TRIP_LOCK       6
`define ST_WARNING         7
`define ST_AT_REF          8
`define ST_SERIAL_OK       9
`define ST_FREQ_OK         10
`define ST_RUNNING         11
`define ST_VOLT_WARN       13
`define ST_CUR_LIMIT       14
`define ST_THERM_WARN      15

// Configuration encodings
`define PROFILE_NATIVE     2'h1
`define REV_SRC_DIGITAL    2'h0
`define REV_SRC_SERIAL     2'h1
`define REV_SRC_OR         2'h2
`define REV_SRC_AND        2'h3

// Conversion index values
`define CONV_IDX_TENTH     8'sh49
`define CONV_IDX_MIN       -8'sh05
`define CONV_IDX_MAX       8'sh02

// Reset values
`define WORD_ZERO          16'h0000
`define CMD_RESET_VALUE    16'h0000

`endif

// ===== conv_scale.v
`timescale 1ns/1ps
`default_nettype none
`include "drive_words_regs.vh"

// ****************************************************************
// Conversion factor scaling
// ****************************************************************
// Scales a whole-number value by ten to the signed index. Negative
// indices give a divisor; the value itself passes through undivided.
module conv_scale (
    input  wire              clk,
    input  wire              resetn,
    input  wire              load,
    input  wire signed [7:0] conv_index,
    input  wire signed [31:0] raw_value,
    output reg  signed [47:0] scaled_value,
    output reg  [16:0]       divisor,
    output reg               index_bad
);

    reg signed [47:0] scaled_d;
    reg [16:0]        div_d;
    reg               bad_d;
    reg signed [47:0] wide;

    // Power-of-ten decode, index 73 is an alias of -1
    always @* begin
        wide     = {{16{raw_value[31]}}, raw_value};
        scaled_d = wide;
        div_d    = 17'h0_0001;
        bad_d    = 1'b0;
        case (conv_index)
            8'sh02:  scaled_d = wide * 48'sh0000_0000_0064;
            8'sh01:  scaled_d = wide * 48'sh0000_0000_000A;
            8'sh00:  scaled_d = wide;
            -8'sh01: div_d = 17'h0_000A;
            -8'sh02: div_d = 17'h0_0064;
            -8'sh03: div_d = 17'h0_03E8;
            -8'sh04: div_d = 17'h0_2710;
            -8'sh05: div_d = 17'h1_86A0;
            `CONV_IDX_TENTH: div_d = 17'h0_000A;
            default: bad_d = 1'b1;
        endcase
    end

    // Registered result, held until the next load
    always @(posedge clk) begin
        if (!resetn) begin
            scaled_value <= 48'sh0000_0000_0000;
            divisor      <= 17'h0_0001;
            index_bad    <= 1'b0;
        end else if (load) begin
            scaled_value <= scaled_d;
            divisor      <= div_d;
            index_bad    <= bad_d;
        end
    end

endmodule // conv_scale

`default_nettype wire

// ===== drive_control_status_words.v
// Summary of operation
// - Two 16-bit process words: command then reference in, state then frequency out.
// - Parameter integers are scaled by ten to a signed index; index 73 means 0.1.
// - Command word acted on only when bit 10 is set; otherwise ignored.
// - Bits 01 and 00 select one of four preset references.
// - Bit 02 low requests DC braking and stop.
// - Bit 03 low switches the output stage off; motor coasts.
// - Bit 04 low requests quick stop over the quick-stop ramp.
// - Bit 05 low freezes output frequency; only speed up/down inputs change it.
// - While frozen only coast, DC brake or their inputs stop the drive.
// - Bit 06 low ramps to stop with selected ramp while the start input is low; high permits start.
// - Trip reset only on a rising edge of bit 07.
// - Bit 08 high selects the jog frequency.
// - Bit 09 selects ramp pair one or two.
// - Bit 11 drives the digital output, bit 12 the relay output.
// - Bits 14 and 13 select one of four setups.
// - Bit 15 reverses only when reversing source is serial, OR or AND.
// - State bit 00 shows ready for operation.
// - State bit 01 shows ready with a coasting command active.
// - State bit 02 shows the drive can start on a start command.
// - State word carries trip, lock, warning, reference, limits and running flags.
// - State bit 03 shows a trip awaiting reset.
// - State bit 06 shows trip lock; the reset bit cannot clear it.
`timescale 1ns/1ps
`default_nettype none
`include "drive_words_regs.vh"

module drive_control_status_words (
    input  wire               clk,
    input  wire               resetn,
    // Process words from the master
    input  wire [15:0]        process_word_first_in,
    input  wire [15:0]        process_word_second_in,
    input  wire               words_strobe,
    // Configuration settings
    input  wire [1:0]         drive_native_profile,
    input  wire               multi_setup_en,
    input  wire [1:0]         reverse_source,
    input  wire               reverse_input,
    input  wire               coast_input_n,
    input  wire               dc_brake_input_n,
    input  wire               speed_up_input,
    input  wire               speed_down_input,
    // Drive state inputs
    input  wire               drive_ready,
    input  wire               trip_event,
    input  wire               trip_lock_event,
    input  wire               power_restored,
    input  wire               warning,
    input  wire               at_reference,
    input  wire               serial_allowed,
    input  wire               freq_in_limits,
    input  wire               start_input,
    input  wire               volt_warning,
    input  wire               current_limit,
    input  wire               thermal_warning,
    input  wire [15:0]        output_frequency,
    // Parameter conversion
    input  wire               param_load,
    input  wire signed [7:0]  param_conv_index,
    input  wire signed [31:0] param_raw,
    output wire signed [47:0] param_scaled,
    output wire [16:0]        param_divisor,
    output wire               param_index_bad,
    // Process words to the master
    output reg  [15:0]        process_word_first_out,
    output reg  [15:0]        process_word_second_out,
    // Drive commands
    output reg  [15:0]        speed_reference,
    output reg  [1:0]         preset_select,
    output reg                dc_brake,
    output reg                coast,
    output reg                quick_stop,
    output reg                freeze,
    output reg                ramp_stop,
    output reg                run_enable,
    output reg                jog_select,
    output reg                ramp_pair2,
    output reg                digital_output,
    output reg                relay_output,
    output reg  [1:0]         setup_select,
    output reg                reverse,
    output reg                trip_reset_pulse,
    output reg                freq_step_up,
    output reg                freq_step_down,
    output reg                tripped,
    output reg                trip_locked
);

    // ************************************************************
    // Synchronisers for pin inputs
    // ************************************************************
    // Two stages each; only stage two is read by logic
    reg [5:0] pin_s1_q;
    reg [5:0] pin_s2_q;
    wire [5:0] pin_raw;

    assign pin_raw = {reverse_input, coast_input_n, dc_brake_input_n,
                      speed_up_input, speed_down_input, start_input};

    // Reset state mirrors inactive pins (stop inputs are active low)
    always @(posedge clk) begin
        if (!resetn) begin
            pin_s1_q <= 6'h18;
            pin_s2_q <= 6'h18;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    wire rev_pin     = pin_s2_q[5];
    wire coast_pin_n = pin_s2_q[4];
    wire brake_pin_n = pin_s2_q[3];
    wire up_pin      = pin_s2_q[2];
    wire down_pin    = pin_s2_q[1];
    wire start_pin   = pin_s2_q[0];

    // ************************************************************
    // Command word capture
    // ************************************************************
    // Word accepted only with valid bit under the native profile
    wire cmd_take = words_strobe && process_word_first_in[`CMD_VALID]
                    && (drive_native_profile == `PROFILE_NATIVE);

    reg [15:0] cmd_q;
    reg [15:0] ref_q;
    reg        reset_bit_q;

    // First word is command, second is reference
    always @(posedge clk) begin
        if (!resetn) begin
            cmd_q       <= `CMD_RESET_VALUE;
            ref_q       <= `WORD_ZERO;
            reset_bit_q <= 1'b0;
        end else if (cmd_take) begin
            cmd_q       <= process_word_first_in;
            ref_q       <= process_word_second_in;
            reset_bit_q <= process_word_first_in[`CMD_RESET];
        end
    end

    // Edge on the accepted reset bit; steady level never resets
    wire reset_edge = cmd_take && process_word_first_in[`CMD_RESET] && !reset_bit_q;

    // Before any valid word arrives, cmd_q is all zero, so the drive sits
    // in a safe coasting state rather than running on stale bits.
    wire coast_req   = !cmd_q[`CMD_COAST_N] || !coast_pin_n;
    wire brake_req   = !cmd_q[`CMD_DC_BRAKE_N] || !brake_pin_n;
    wire freeze_req  = !cmd_q[`CMD_FREEZE_N];
    wire start_req   = cmd_q[`CMD_START] || start_pin;

    reg rev_sel;

    // Reversing source decode
    always @* begin
        case (reverse_source)
            `REV_SRC_SERIAL: rev_sel = cmd_q[`CMD_REVERSE];
            `REV_SRC_OR:     rev_sel = cmd_q[`CMD_REVERSE] || rev_pin;
            `REV_SRC_AND:    rev_sel = cmd_q[`CMD_REVERSE] && rev_pin;
            default:         rev_sel = rev_pin;
        endcase
    end

    // ************************************************************
    // Drive command outputs
    // ************************************************************
    // Frozen drive ignores start and ramp stop; only coast or brake stop it
    always @(posedge clk) begin
        if (!resetn) begin
            speed_reference <= `WORD_ZERO;
            preset_select   <= 2'h0;
            dc_brake        <= 1'b0;
            coast           <= 1'b1;
            quick_stop      <= 1'b0;
            freeze          <= 1'b0;
            ramp_stop       <= 1'b1;
            run_enable      <= 1'b0;
            jog_select      <= 1'b0;
            ramp_pair2      <= 1'b0;
            digital_output  <= 1'b0;
            relay_output    <= 1'b0;
            setup_select    <= 2'h0;
            reverse         <= 1'b0;
            freq_step_up    <= 1'b0;
            freq_step_down  <= 1'b0;
        end else begin
            speed_reference <= ref_q;
            preset_select   <= {cmd_q[`CMD_PRESET_HI], cmd_q[`CMD_PRESET_LO]};
            dc_brake        <= brake_req;
            coast           <= coast_req;
            quick_stop      <= !cmd_q[`CMD_QSTOP_N];
            freeze          <= freeze_req;
            if (freeze_req) begin
                ramp_stop   <= 1'b0;
                run_enable  <= !coast_req && !brake_req;
            end else begin
                ramp_stop   <= !start_req;
                run_enable  <= start_req && !coast_req && !brake_req
                               && cmd_q[`CMD_QSTOP_N];
            end
            // Only speed up/down move a frozen frequency
            freq_step_up    <= freeze_req && up_pin && !down_pin;
            freq_step_down  <= freeze_req && down_pin && !up_pin;
            jog_select      <= cmd_q[`CMD_JOG];
            ramp_pair2      <= cmd_q[`CMD_RAMP2];
            digital_output  <= cmd_q[`CMD_DIG_OUT];
            relay_output    <= cmd_q[`CMD_RELAY];
            if (multi_setup_en) begin
                setup_select <= {cmd_q[`CMD_SETUP_HI], cmd_q[`CMD_SETUP_LO]};
            end
            reverse         <= rev_sel;
        end
    end

    // ************************************************************
    // Trip and trip lock
    // ************************************************************
    // New trip wins over a reset arriving in the same cycle
    always @(posedge clk) begin
        if (!resetn) begin
            tripped          <= 1'b0;
            trip_locked      <= 1'b0;
            trip_reset_pulse <= 1'b0;
        end else begin
            trip_reset_pulse <= reset_edge && tripped && !trip_locked;
            if (trip_event || trip_lock_event) begin
                tripped <= 1'b1;
            end else if (reset_edge && !trip_locked) begin
                tripped <= 1'b0;
            end else if (power_restored && trip_locked) begin
                tripped <= 1'b0;
            end
            if (trip_lock_event) begin
                trip_locked <= 1'b1;
            end else if (power_restored) begin
                trip_locked <= 1'b0;
            end
        end
    end

    // ************************************************************
    // State word assembly
    // ************************************************************
    reg [15:0] state_d;

    // Unused bits stay zero by the initial clear
    always @* begin
        state_d = `WORD_ZERO;
        state_d[`ST_READY]       = drive_ready;
        state_d[`ST_DRIVE_READY] = drive_ready && coast_req;
        state_d[`ST_CAN_START]   = drive_ready && !coast_req && !brake_req && !tripped;
        state_d[`ST_TRIP]        = tripped;
        state_d[`ST_TRIP_LOCK]   = trip_locked;
        state_d[`ST_WARNING]     = warning;
        state_d[`ST_AT_REF]      = at_reference;
        state_d[`ST_SERIAL_OK]   = serial_allowed;
        state_d[`ST_FREQ_OK]     = freq_in_limits;
        state_d[`ST_RUNNING]     = run_enable || (output_frequency != `WORD_ZERO);
        state_d[`ST_VOLT_WARN]   = volt_warning;
        state_d[`ST_CUR_LIMIT]   = current_limit;
        state_d[`ST_THERM_WARN]  = thermal_warning;
    end

    // State word first, present frequency second
    always @(posedge clk) begin
        if (!resetn) begin
            process_word_first_out  <= `WORD_ZERO;
            process_word_second_out <= `WORD_ZERO;
        end else begin
            process_word_first_out  <= state_d;
            process_word_second_out <= output_frequency;
        end
    end

    // ************************************************************
    // Parameter value scaling
    // ************************************************************
    conv_scale u_conv_scale (
        .clk          (clk),
        .resetn       (resetn),
        .load         (param_load),
        .conv_index   (param_conv_index),
        .raw_value    (param_raw),
        .scaled_value (param_scaled),
        .divisor      (param_divisor),
        .index_bad    (param_index_bad)
    );

endmodule // drive_control_status_words

`default_nettype wire

// ===== bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Bus master model
// ********************
module bus_master_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] cmd,
    input  wire logic [15:0] ref_w,
    output var  logic [15:0] word_first,
    output var  logic [15:0] word_second,
    output var  logic        strobe
);
    // Idle words toggle so stale data never looks valid
    initial begin
        strobe = 1'h0;
        word_first = 16'h0000;
        word_second = 16'h0000;
    end
    // Command first, reference second, one telegram per cycle
    always @(posedge clk) begin
        strobe <= go;
        word_first <= go ? cmd : ~word_first;
        word_second <= go ? ref_w : ~word_second;
    end
endmodule // bus_master_model
`default_nettype wire

// ===== drive_control_status_words_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Word checker
// ********************
module drive_words_assertions (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [15:0] process_word_first_in,
    input wire logic        words_strobe,
    input wire logic [1:0]  drive_native_profile,
    input wire logic        multi_setup_en,
    input wire logic [1:0]  reverse_source,
    input wire logic        trip_event,
    input wire logic        power_restored,
    input wire logic        drive_ready,
    input wire logic [15:0] output_frequency,
    input wire logic [15:0] process_word_first_out,
    input wire logic [15:0] process_word_second_out,
    input wire logic [1:0]  preset_select,
    input wire logic [1:0]  setup_select,
    input wire logic        relay_output,
    input wire logic        digital_output,
    input wire logic        jog_select,
    input wire logic        reverse,
    input wire logic        trip_reset_pulse,
    input wire logic        tripped,
    input wire logic        trip_locked
);
    // Accepted and refused telegrams
    wire take = words_strobe && process_word_first_in[10] && drive_native_profile == 2'h1;
    wire drop = words_strobe && !take;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    preset_map_a: assert property (take |-> ##2 preset_select == $past(process_word_first_in[1:0], 2))
        else $error("preset select wrong");
    output_bits_a: assert property (take |-> ##2 {relay_output, digital_output, jog_select}
        == {$past(process_word_first_in[12:11], 2), $past(process_word_first_in[8], 2)})
        else $error("direct outputs wrong");
    refused_word_a: assert property (drop |-> ##2 $stable(relay_output) && $stable(jog_select))
        else $error("refused word acted on");
    reverse_serial_a: assert property ((take && reverse_source == 2'h1 ##2 reverse_source == 2'h1)
        |-> reverse == $past(process_word_first_in[15], 2))
        else $error("reverse wrong");
    setup_take_a: assert property ((take && multi_setup_en ##2 multi_setup_en)
        |-> setup_select == $past(process_word_first_in[14:13], 2))
        else $error("setup select wrong");
    setup_hold_a: assert property (!multi_setup_en [*3] |-> $stable(setup_select))
        else $error("setup moved while single setup");
    trip_set_a: assert property (trip_event && !power_restored |=> tripped)
        else $error("trip not flagged");
    lock_hold_a: assert property (trip_locked && !power_restored |=> trip_locked && tripped)
        else $error("trip lock lost");
    reset_pulse_a: assert property (trip_reset_pulse |=> !trip_reset_pulse)
        else $error("reset pulse too long");
    state_flags_a: assert property ($past(resetn) |-> {process_word_first_out[6],
        process_word_first_out[3], process_word_first_out[0]}
        == {$past(trip_locked), $past(tripped), $past(drive_ready)})
        else $error("state flags wrong");
    unused_zero_a: assert property (process_word_first_out[5:4] == 2'h0 && !process_word_first_out[12])
        else $error("unused state bits set");
    freq_echo_a: assert property ($past(resetn) |-> process_word_second_out == $past(output_frequency))
        else $error("frequency word wrong");
    cover property (take);
    cover property (drop);
    cover property (trip_reset_pulse);
endmodule // drive_words_assertions
`default_nettype wire

// ===== drive_control_status_words_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Bench
// ********************
module drive_control_status_words_bench;
    logic clk = 1'h0, resetn = 1'h0, go = 1'h0, multi_setup_en = 1'h1, reverse_input = 1'h0;
    logic coast_input_n = 1'h1, dc_brake_input_n = 1'h1, speed_up_input = 1'h0;
    logic speed_down_input = 1'h0, start_input = 1'h0, drive_ready = 1'h0, trip_event = 1'h0;
    logic trip_lock_event = 1'h0, power_restored = 1'h0, warning = 1'h0, at_reference = 1'h0;
    logic serial_allowed = 1'h0, freq_in_limits = 1'h0, param_load = 1'h0, volt_warning = 1'h0;
    logic current_limit = 1'h0, thermal_warning = 1'h0, trip_m = 1'h0, lock_m = 1'h0, bad;
    logic [1:0]  drive_native_profile = 2'h1, reverse_source = 2'h1, setup_m = 2'h0;
    logic [15:0] cmd = 16'h0000, ref_w = 16'h0000, output_frequency = 16'h0000;
    logic [15:0] last_cmd = 16'h0000, ref_m = 16'h0000, w, exp;
    logic signed [7:0]  param_conv_index = 8'sh00;
    logic signed [31:0] param_raw = 32'sh0000_0000;
    wire [15:0] process_word_first_in, process_word_second_in, speed_reference;
    wire [15:0] process_word_first_out, process_word_second_out;
    wire [1:0]  preset_select, setup_select;
    wire signed [47:0] param_scaled;
    wire [16:0] param_divisor;
    wire words_strobe, param_index_bad, dc_brake, coast, quick_stop, freeze, ramp_stop;
    wire run_enable, jog_select, ramp_pair2, digital_output, relay_output, reverse;
    wire trip_reset_pulse, freq_step_up, freq_step_down, tripped, trip_locked;
    int mismatches = 0, samples_checked = 0, raw, div, pulses = 0, pulses_m = 0;
    longint sc;
    int idx_q[$] = '{73, 2, 1, 0, -1, -2, -3, -4, -5, 3, -6};
    drive_control_status_words drive_control_status_words_inst (.*);
    bus_master_model bus_master_model_inst (.clk(clk), .go(go), .cmd(cmd), .ref_w(ref_w),
        .word_first(process_word_first_in), .word_second(process_word_second_in),
        .strobe(words_strobe));
    // 50 MHz clock
    always #10 clk = ~clk;
    // Reset pulses seen, one count per standing cycle
    always @(posedge clk) pulses += (trip_reset_pulse === 1'b1);
    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] ex);
        samples_checked++;
        if (seen !== ex) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, ex, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Model: remember last accepted word, trip clears on a rising reset bit only
    function automatic void apply(input logic [15:0] v);
        if (v[10] && drive_native_profile == 2'h1) begin
            pulses_m += (v[7] && !last_cmd[7] && !lock_m && trip_m);
            if (v[7] && !last_cmd[7] && !lock_m) trip_m = 1'h0;
            if (multi_setup_en) setup_m = v[14:13];
            ref_m = ref_w;
            last_cmd = v;
        end
    endfunction
    // One or two telegrams back to back, then outputs have settled
    task automatic send(input logic [15:0] a, input logic [15:0] b, input int n);
        tick(1);
        cmd <= a;
        ref_w <= 16'($urandom);
        go <= 1'h1;
        tick(1);
        cmd <= b;
        if (n == 2)
            tick(1);
        go <= 1'h0;
        tick(4);
        #1;
        apply(a);
        if (n == 2)
            apply(b);
    endtask
    task automatic chk_cmd;
        check("preset", preset_select, last_cmd[1:0]);
        check("dc_brake", dc_brake, !last_cmd[2]);
        check("coast", coast, !last_cmd[3]);
        check("quick_stop", quick_stop, !last_cmd[4]);
        check("freeze", freeze, !last_cmd[5]);
        check("ramp_stop", ramp_stop, last_cmd[5] & !last_cmd[6]);
        if (!last_cmd[5])
            check("run_frozen", run_enable, last_cmd[3] & last_cmd[2]);
        else
            check("run", run_enable, &last_cmd[6:2]);
        check("speed_ref", speed_reference, ref_m);
        check("jog", jog_select, last_cmd[8]);
        check("ramp2", ramp_pair2, last_cmd[9]);
        check("outputs", {relay_output, digital_output}, last_cmd[12:11]);
        check("setup", setup_select, setup_m);
        check("tripped", tripped, trip_m);
    endtask
    // Trip (0), trip lock (1) or power restored (2)
    task automatic pulse(input int k);
        tick(1);
        if (k == 0)
            trip_event <= 1'h1;
        else if (k == 1)
            trip_lock_event <= 1'h1;
        else
            power_restored <= 1'h1;
        tick(1);
        {trip_event, trip_lock_event, power_restored} <= 3'h0;
        tick(2);
        #1;
        trip_m = (k < 2);
        lock_m = (k == 1) ? 1'h1 : ((k == 2) ? 1'h0 : lock_m);
        check("lock", trip_locked, lock_m);
        check("st_trip", {process_word_first_out[6], process_word_first_out[3]}, {lock_m, trip_m});
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("run limit reached");
        complete_run;
    end
    // Main sequence
    initial begin
        void'($urandom(27619));
        tick(4);
        resetn <= 1'h1;
        tick(3);
        #1;
        chk_cmd;
        check("divisor_rst", param_divisor, 17'h1);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            tick(1);
            reverse_source <= 2'(i);
            reverse_input <= 1'(i / 12);
            multi_setup_en <= 1'((i / 3) % 2);
            w = 16'($urandom) | 16'h0400;
            send(w, w, 1);
            check("reverse", reverse, (i % 4 == 0) ? reverse_input : (i % 4 == 1) ? w[15]
                : (i % 4 == 2) ? w[15] | reverse_input : w[15] & reverse_input);
            chk_cmd;
        end
        $display("test commands done");
        for (int p = 0; p < 4; p++) begin
            tick(1);
            drive_native_profile <= 2'(p);
            w = 16'($urandom) | 16'h0400;
            w[10] = (p != 1);
            send(w, w, 1);
            chk_cmd;
        end
        tick(1);
        drive_native_profile <= 2'h1;
        send(16'h1C00, 16'h0000, 2);
        chk_cmd;
        $display("test refused done");
        pulse(0);
        send(16'h0400, 16'h0480, 2);
        chk_cmd;
        pulse(0);
        send(16'h0480, 16'h0480, 1);
        chk_cmd;
        pulse(1);
        send(16'h0400, 16'h0480, 2);
        chk_cmd;
        pulse(2);
        check("reset_pulses", pulses, pulses_m);
        $display("test trip done");
        for (int i = 0; i < 12; i++) begin
            tick(1);
            {drive_ready, warning, at_reference, serial_allowed, freq_in_limits, volt_warning,
                current_limit, thermal_warning, start_input, speed_up_input,
                speed_down_input} <= 11'($urandom);
            output_frequency <= 16'($urandom) | 16'h0001;
            tick(3);
            #1;
            exp = {thermal_warning, current_limit, volt_warning, 2'h1, freq_in_limits,
                serial_allowed, at_reference, warning, lock_m, 2'h0, trip_m, 2'h0, drive_ready};
            check("state", process_word_first_out & 16'hFFF9, exp);
            check("frequency", process_word_second_out, output_frequency);
            check("step_up", freq_step_up, !last_cmd[5] & speed_up_input & !speed_down_input);
            check("step_down", freq_step_down, !last_cmd[5] & speed_down_input & !speed_up_input);
        end
        $display("test state done");
        send(16'h047C, 16'h047C, 1);
        tick(1);
        drive_ready <= 1'h1;
        tick(2);
        #1;
        check("can_start", process_word_first_out[2:1], 2'h2);
        tick(1);
        coast_input_n <= 1'h0;
        tick(6);
        #1;
        check("pin_coast", {coast, process_word_first_out[2:1]}, 3'h5);
        tick(1);
        coast_input_n <= 1'h1;
        $display("test pins done");
        foreach (idx_q[i]) begin
            raw = int'($urandom % 2001) - 1000;
            tick(1);
            param_conv_index <= 8'(idx_q[i]);
            param_raw <= raw;
            param_load <= 1'h1;
            tick(1);
            param_load <= 1'h0;
            tick(1);
            #1;
            bad = !(idx_q[i] == 73 || (idx_q[i] >= -5 && idx_q[i] <= 2));
            check("index_bad", param_index_bad, bad);
            if (!bad) begin
                div = (idx_q[i] == 73) ? 10 : ((idx_q[i] < 0) ? 10 ** (-idx_q[i]) : 1);
                sc = (idx_q[i] >= 0 && idx_q[i] != 73) ? raw * (10 ** idx_q[i]) : raw;
                check("divisor", param_divisor, 48'(div));
                check("scaled", param_scaled, 48'(sc));
            end
        end
        $display("test scaling done");
        complete_run;
    end
endmodule // drive_control_status_words_bench
bind drive_control_status_words drive_words_assertions drive_words_assertions_inst (.*);
`default_nettype wire
